// ==== design/flash_prog_pkg.sv ====
// Shared constants and types for the flash program command sequencer
package flash_prog_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int ADDR_W   = 24;  // Word address width
    localparam int LINE_W   = 8;   // Word index inside a 512-byte line
    localparam int SECT_LSB = 17;  // 256KB sector in words
    localparam int CA_BYTES = 6;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
    } wr_s;

    typedef struct packed {
        logic              re;
        logic              we;
        logic [2:0]        space;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       wdata;
    } arr_s;

    // ****************************************
    // Command words
    // ****************************************
    localparam logic [10:0] UNL1_ADDR  = 11'h555;
    localparam logic [10:0] UNL2_ADDR  = 11'h2aa;
    localparam logic [7:0]  UNL1_DATA  = 8'haa;
    localparam logic [7:0]  UNL2_DATA  = 8'h55;
    localparam logic [7:0]  CMD_SETUP  = 8'ha0;
    localparam logic [7:0]  CMD_WBUF   = 8'h25;
    localparam logic [7:0]  CMD_COMMIT = 8'h29;
    localparam logic [7:0]  CMD_SUSP   = 8'hb0;
    localparam logic [7:0]  CMD_RESUME = 8'h30;
    localparam logic [7:0]  CMD_CLR    = 8'h71;
    localparam logic [7:0]  CMD_ABRST  = 8'hf0;
    localparam logic [15:0] MAX_WCNT   = 16'h00ff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // ****************************************
    // Address space overlays
    // ****************************************
    localparam logic [2:0] OVL_ARRAY = 3'h0;
    localparam logic [2:0] OVL_OTP   = 3'h1;
    localparam logic [2:0] OVL_PROT  = 3'h2;  // First of the protection overlays
    localparam logic [2:0] OVL_LAST  = 3'h6;

    // ****************************************
    // Status and registers
    // ****************************************
    localparam int STS_RDY    = 7;
    localparam int STS_PFAIL  = 4;
    localparam int STS_BABORT = 3;
    localparam int STS_SUSP   = 2;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam logic [2:0] CTRL_RST   = 3'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS       = 10;
    localparam int PULSE_NS     = 1000;
    localparam int RPH_NS       = 1000;
    localparam int PULSE_CYC_D  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RPH_CYC_D    = (RPH_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== design/flash_prog_seq.sv ====
// Program command sequencer: link capture, command decode, buffer and embedded program
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module flash_prog_seq
    import flash_prog_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_CYC_D,
    parameter int RPH_CYC   = RPH_CYC_D
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RSTN,
    input  wire logic                   CE,
    // Memory link pins
    input  wire logic                   LCLK,
    input  wire logic                   CS_N,
    input  wire logic [7:0]             DQ,
    input  wire logic                   RESET_N,
    // Register port
    input  wire logic [3:0]             REG_ADDR,
    input  wire logic [31:0]            REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic      [31:0]            REG_RDATA,
    // Array access
    output flash_prog_pkg::arr_s        ARR,
    input  wire logic [15:0]            ARR_RDATA,
    // Protection lookup
    output logic [ADDR_W-SECT_LSB-1:0]  LOCK_SECT,
    input  wire logic                   LOCK_HIT,
    // Erase suspend context
    input  wire logic                   ERS_SUSP,
    output logic                        ERS_STBY
);
    import flash_prog_pkg::*;

    // Array read then AND-write needs four cycles per word
    if (PULSE_CYC < 4 || PULSE_CYC > 4095 || RPH_CYC < 1 || RPH_CYC > 4095) begin : g_chk
        $error("flash_prog_seq: timing parameter out of range");
    end

    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_UNL1   = 11'h002,
        ST_UNL2   = 11'h004,
        ST_WCNT   = 11'h008,
        ST_LOAD   = 11'h010,
        ST_COMMIT = 11'h020,
        ST_SETUP  = 11'h040,
        ST_WLOAD  = 11'h080,
        ST_PROG   = 11'h100,
        ST_SUSP   = 11'h200,
        ST_RREC   = 11'h400
    } state_e;

    function automatic logic [ADDR_W-SECT_LSB-1:0] sect(input logic [ADDR_W-1:0] a);
        sect = a[ADDR_W-1:SECT_LSB];
    endfunction

    function automatic logic [ADDR_W-LINE_W-1:0] line(input logic [ADDR_W-1:0] a);
        line = a[ADDR_W-1:LINE_W];
    endfunction

    // ****************************************
    // Link capture
    // ****************************************
    logic [10:0]       s1_q, s2_q, s3_q;
    logic              lclk_v_q, cs_v_q, rst_v_q;
    logic [47:0]       ca_q;
    logic [2:0]        bc_q;
    logic              hi_ph_q;
    logic [7:0]        hi_q;
    logic [ADDR_W-1:0] wi_q;
    logic              ev_q, cs_end_q;
    wr_s               ev_w_q;
    logic              lk_edge;
    logic [ADDR_W-1:0] ca_addr;

    // Order: reset pin, chip select, link clock, data
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s1_q <= 11'h600;
            s2_q <= 11'h600;
            s3_q <= 11'h600;
        end else if (CE) begin
            s1_q <= {RESET_N, CS_N, LCLK, DQ};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once the two late stages agree
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rst_v_q  <= 1'b1;
            cs_v_q   <= 1'b1;
            lclk_v_q <= 1'b0;
        end else if (CE) begin
            if (s2_q[10] == s3_q[10]) rst_v_q <= s3_q[10];
            if (s2_q[9] == s3_q[9]) cs_v_q <= s3_q[9];
            if (s2_q[8] == s3_q[8]) lclk_v_q <= s3_q[8];
        end
    end

    assign lk_edge = !cs_v_q && (s2_q[8] == s3_q[8]) && (s3_q[8] != lclk_v_q);
    assign ca_addr = {ca_q[ADDR_W+12:16], ca_q[2:0]};

    // Both link clock edges carry a byte; high byte of each word first
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ca_q     <= 48'h0;
            bc_q     <= 3'h0;
            hi_ph_q  <= 1'b1;
            hi_q     <= 8'h00;
            wi_q     <= '0;
            ev_q     <= 1'b0;
            ev_w_q   <= '0;
            cs_end_q <= 1'b0;
        end else if (CE) begin
            ev_q     <= 1'b0;
            cs_end_q <= 1'b0;
            if (cs_v_q) begin
                bc_q    <= 3'h0;
                hi_ph_q <= 1'b1;
                wi_q    <= '0;
            end
            if (s2_q[9] == s3_q[9] && s3_q[9] && !cs_v_q) cs_end_q <= 1'b1;
            if (lk_edge) begin
                if (bc_q != 3'(CA_BYTES)) begin
                    ca_q <= {ca_q[39:0], s3_q[7:0]};
                    bc_q <= bc_q + 3'h1;
                end else if (hi_ph_q) begin
                    hi_q    <= s3_q[7:0];
                    hi_ph_q <= 1'b0;
                end else begin
                    hi_ph_q     <= 1'b1;
                    wi_q        <= wi_q + 1'b1;
                    ev_q        <= !ca_q[47];
                    ev_w_q.addr <= ca_addr + wi_q;
                    ev_w_q.data <= {hi_q, s3_q[7:0]};
                end
            end
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    state_e                     state_q, state_d;
    logic [2:0]                 ovl_q;
    logic [ADDR_W-SECT_LSB-1:0] sa_q;
    logic [ADDR_W-LINE_W-1:0]   line_q;
    logic [ADDR_W-1:0]          nxt_q;
    logic [7:0]                 cnt_q, start_q, end_q, idx_q;
    logic                       first_q;
    logic [15:0]                buf_q [256];
    logic [255:0]               vld_q;
    logic [11:0]                tmr_q, rec_q;
    logic                       abort, lock_fail, clr, take_sa, take_cnt, store, prog_done;
    logic                       prot_ovl, buf_ovl, is_unl1, is_unl2, sa_ok, step_done;
    logic [7:0]                 cmd;

    assign cmd       = ev_w_q.data[7:0];
    assign prot_ovl  = ovl_q >= OVL_PROT && ovl_q <= OVL_LAST;
    assign buf_ovl   = ovl_q == OVL_ARRAY || ovl_q == OVL_OTP;
    assign is_unl1   = ev_w_q.addr[10:0] == UNL1_ADDR && cmd == UNL1_DATA;
    assign is_unl2   = ev_w_q.addr[10:0] == UNL2_ADDR && cmd == UNL2_DATA;
    assign sa_ok     = sect(ev_w_q.addr) == sa_q;
    assign step_done = !vld_q[idx_q] || tmr_q == 12'(PULSE_CYC - 1);
    assign prog_done = state_q == ST_PROG && step_done && idx_q == end_q;
    assign LOCK_SECT = state_q == ST_SETUP ? sect(ev_w_q.addr) : sa_q;

    always_comb begin
        state_d   = state_q;
        abort     = 1'b0;
        lock_fail = 1'b0;
        clr       = 1'b0;
        take_sa   = 1'b0;
        take_cnt  = 1'b0;
        store     = 1'b0;
        case (state_q)
            ST_IDLE: if (ev_q) begin
                if (is_unl1) state_d = ST_UNL1;
                else if (prot_ovl && cmd == CMD_SETUP) state_d = ST_SETUP;
                else if (cmd == CMD_CLR) clr = 1'b1;
            end
            ST_UNL1: if (ev_q) state_d = is_unl2 ? ST_UNL2 : ST_IDLE;
            ST_UNL2: if (ev_q) begin
                state_d = ST_IDLE;
                if (cmd == CMD_SETUP) begin
                    state_d = ST_SETUP;
                end else if (cmd == CMD_WBUF && buf_ovl) begin
                    state_d = ST_WCNT;
                    take_sa = 1'b1;
                end else if (cmd == CMD_ABRST) begin
                    clr = 1'b1;
                end
            end
            ST_WCNT: if (ev_q) begin
                if (!sa_ok || ev_w_q.data > MAX_WCNT) begin
                    abort   = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    take_cnt = 1'b1;
                    state_d  = ST_LOAD;
                end
            end
            ST_LOAD: if (ev_q) begin
                // Every write is data here, command codes included
                if (first_q ? !sa_ok
                            : (line(ev_w_q.addr) != line_q || ev_w_q.addr != nxt_q)) begin
                    abort   = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    store = 1'b1;
                    if (cnt_q == 8'h00) state_d = ST_COMMIT;
                end
            end
            ST_COMMIT: if (ev_q) begin
                state_d = ST_IDLE;
                if (cmd != CMD_COMMIT || !sa_ok) abort = 1'b1;
                else if (LOCK_HIT) lock_fail = 1'b1;
                else state_d = ST_PROG;
            end
            ST_SETUP: if (ev_q) begin
                if (LOCK_HIT) begin
                    lock_fail = 1'b1;
                    state_d   = ST_IDLE;
                end else begin
                    store   = 1'b1;
                    state_d = ST_WLOAD;
                end
            end
            ST_WLOAD: begin
                if (cs_end_q) state_d = ST_PROG;
                else if (ev_q && line(ev_w_q.addr) == line_q) store = 1'b1;
            end
            ST_PROG: begin
                if (ev_q && cmd == CMD_SUSP) state_d = ST_SUSP;
                else if (prog_done) state_d = ST_IDLE;
            end
            ST_SUSP: if (ev_q && cmd == CMD_RESUME) state_d = ST_PROG;
            ST_RREC: if (rec_q == 12'h000) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
        if (!rst_v_q) state_d = ST_RREC;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) state_q <= ST_IDLE;
        else if (CE) state_q <= state_d;
    end

    // ****************************************
    // Sequence bookkeeping
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sa_q      <= '0;
            cnt_q     <= 8'h00;
            first_q   <= 1'b0;
            line_q    <= '0;
            nxt_q     <= '0;
            start_q   <= 8'h00;
            end_q     <= 8'h00;
            rec_q     <= 12'h000;
            ERS_STBY  <= 1'b0;
        end else if (CE) begin
            if (take_sa) begin
                sa_q     <= sect(ev_w_q.addr);
                ERS_STBY <= ERS_SUSP;
            end
            if (state_q == ST_IDLE && state_d == ST_SETUP) ERS_STBY <= ERS_SUSP;
            if (take_cnt) begin
                cnt_q   <= ev_w_q.data[7:0];
                first_q <= 1'b1;
            end
            if (store) begin
                if (state_q == ST_LOAD) cnt_q <= cnt_q - 8'h01;
                if (first_q || state_q == ST_SETUP) begin
                    line_q  <= line(ev_w_q.addr);
                    start_q <= ev_w_q.addr[LINE_W-1:0];
                end
                first_q <= 1'b0;
                nxt_q   <= ev_w_q.addr + 1'b1;
                end_q   <= ev_w_q.addr[LINE_W-1:0];
            end
            if (state_d == ST_RREC && state_q != ST_RREC) rec_q <= 12'(RPH_CYC - 1);
            else if (rec_q != 12'h000) rec_q <= rec_q - 12'h001;
        end
    end

    // ****************************************
    // Write buffer
    // ****************************************
    // A valid map stands in for the erased preset: the engine skips unloaded slots
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            vld_q <= '0;
        end else if (CE) begin
            vld_q <= ((take_cnt || state_q == ST_SETUP) ? '0 : vld_q)
                   | (store ? (256'h1 << ev_w_q.addr[LINE_W-1:0]) : '0);
        end
    end

    always_ff @(posedge CLK) begin
        if (CE && store) buf_q[ev_w_q.addr[LINE_W-1:0]] <= ev_w_q.data;
    end

    // ****************************************
    // Embedded program engine
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            idx_q <= 8'h00;
            tmr_q <= 12'h000;
        end else if (CE) begin
            if (state_q != ST_PROG) begin
                // Suspend restarts the word; the AND-write is safe to repeat
                tmr_q <= 12'h000;
                if (state_q != ST_SUSP) idx_q <= start_q;
            end else if (state_d == ST_PROG) begin
                if (step_done) begin
                    tmr_q <= 12'h000;
                    idx_q <= idx_q + 8'h01;
                end else begin
                    tmr_q <= tmr_q + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ARR <= '0;
        end else if (CE) begin
            ARR.re    <= 1'b0;
            ARR.we    <= 1'b0;
            ARR.space <= ovl_q;
            if (state_q == ST_PROG && state_d == ST_PROG && vld_q[idx_q]) begin
                ARR.addr <= {line_q, idx_q};
                if (tmr_q == 12'h000) ARR.re <= 1'b1;
                if (tmr_q == 12'h002) begin
                    ARR.we    <= 1'b1;
                    ARR.wdata <= ARR_RDATA & buf_q[idx_q];
                end
            end
        end
    end

    // ****************************************
    // Status flags and register port
    // ****************************************
    logic pfail_q, babort_q, busy;

    assign busy = |(state_q & (ST_WLOAD | ST_PROG | ST_SUSP | ST_RREC));

    // Abort and clear come from distinct writes, so they never meet
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pfail_q  <= 1'b0;
            babort_q <= 1'b0;
        end else if (CE) begin
            if (abort || lock_fail) pfail_q <= 1'b1;
            else if (clr) pfail_q <= 1'b0;
            if (abort) babort_q <= 1'b1;
            else if (clr) babort_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ovl_q     <= CTRL_RST;
            REG_RDATA <= 32'h0;
        end else if (CE) begin
            if (REG_WR && REG_ADDR == REG_CTRL) ovl_q <= REG_WDATA[2:0];
            REG_RDATA <= 32'h0;
            if (REG_RD && REG_ADDR == REG_STATUS) begin
                REG_RDATA[STS_RDY]    <= !busy;
                REG_RDATA[STS_PFAIL]  <= pfail_q;
                REG_RDATA[STS_BABORT] <= babort_q;
                REG_RDATA[STS_SUSP]   <= state_q == ST_SUSP;
            end else if (REG_RD && REG_ADDR == REG_CTRL) begin
                REG_RDATA[2:0] <= ovl_q;
            end
        end
    end
endmodule // flash_prog_seq

// ==== test/flash_prog_seq_props.sv ====
// Port assertions for the program command sequencer
`timescale 1ns/100ps
module flash_prog_seq_props
    import flash_prog_pkg::*;
#(
    parameter int PULSE_CYC = 8,
    parameter int RPH_CYC   = 20
) (
    // Clock and reset
    input wire logic                   CLK,
    input wire logic                   RSTN,
    input wire logic                   CE,
    input wire logic                   RESET_N,
    // Register port
    input wire logic [3:0]             REG_ADDR,
    input wire logic                   REG_RD,
    input wire logic [31:0]            REG_RDATA,
    // Array side
    input wire flash_prog_pkg::arr_s   ARR,
    input wire logic [15:0]            ARR_RDATA,
    input wire logic                   ERS_STBY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    AST_RD_IDLE: assert property (CE && !REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (REG_RD && REG_ADDR != REG_STATUS && REG_ADDR != REG_CTRL
        |=> REG_RDATA == 32'h0) else $error("unmapped read not zero");
    AST_RST_VAL: assert property ($rose(RSTN) |-> ARR == '0 && !ERS_STBY)
        else $error("outputs not cleared by reset");
    AST_WE_READ: assert property (ARR.we |-> $past(ARR.re, 2) && $past(ARR.addr, 2) == ARR.addr)
        else $error("array write without read of same word");
    AST_CLEAR_ONLY: assert property (ARR.we |-> (ARR.wdata & ~$past(ARR_RDATA)) == 16'h0)
        else $error("array write sets a bit");
    AST_WE_PULSE: assert property (ARR.we |=> !ARR.we)
        else $error("array write longer than one cycle");
    AST_RE_GAP: assert property (ARR.re |=> !ARR.re [*3])
        else $error("words programmed too close together");
    AST_HW_RESET: assert property (!RESET_N [*6] |-> !ARR.re && !ARR.we)
        else $error("array access under hardware reset");
    cover property (ARR.we);
    cover property (REG_RD && REG_ADDR == REG_STATUS ##1 REG_RDATA[STS_BABORT]);
    cover property ($fell(RESET_N));
endmodule // flash_prog_seq_props

// ==== test/link_host.sv ====
// Host model driving write frames onto the octal link
`timescale 1ns/100ps
module link_host (
    // Link pins
    output logic       LCLK,
    output logic       CS_N,
    output logic [7:0] DQ
);
    logic [15:0] wd [0:255];
    initial begin
        LCLK = 1'b0;
        CS_N = 1'b1;
        DQ   = 8'h00;
    end
    // One byte per link clock level change
    task automatic put(input logic [7:0] b);
        DQ = b;
        #31.2;
        LCLK = ~LCLK;
        #31.3;
    endtask
    // Clock stands still between frames; data inverted once deselected
    task automatic frame(input logic [23:0] a, input int n);
        logic [47:0] ca;
        ca = 48'h0;
        ca[36:16] = a[23:3];
        ca[2:0] = a[2:0];
        #100;
        CS_N = 1'b0;
        for (int i = 5; i >= 0; i--) put(ca[i*8+:8]);
        for (int i = 0; i < n; i++) begin
            put(wd[i][15:8]);
            put(wd[i][7:0]);
        end
        CS_N = 1'b1;
        DQ = ~DQ;
    endtask
endmodule // link_host

// ==== test/tb.sv ====
// Self-checking bench for the program command sequencer
`timescale 1ns/100ps
module tb;
    import flash_prog_pkg::*;
    localparam int PULSE = 20;
    localparam int RPH   = 20;
    logic        CLK, RSTN, CE, RESET_N, REG_WR, REG_RD, LOCK_HIT, ERS_SUSP, ERS_STBY;
    logic        LCLK, CS_N;
    logic [7:0]  DQ;
    logic [3:0]  REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, d;
    logic [15:0] ARR_RDATA;
    logic [15:0] p [0:7];
    logic [6:0]  LOCK_SECT;
    arr_s        ARR;
    logic [15:0] mem [logic [23:0]];
    logic [23:0] a, sa;
    int          failures, compares, seed, cyc, n;
    flash_prog_seq #(.PULSE_CYC(PULSE), .RPH_CYC(RPH)) dut (.CLK(CLK), .RSTN(RSTN),
        .CE(CE), .LCLK(LCLK), .CS_N(CS_N), .DQ(DQ), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .ARR(ARR), .ARR_RDATA(ARR_RDATA), .LOCK_SECT(LOCK_SECT), .LOCK_HIT(LOCK_HIT),
        .ERS_SUSP(ERS_SUSP), .ERS_STBY(ERS_STBY));
    link_host host (.LCLK(LCLK), .CS_N(CS_N), .DQ(DQ));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Array with one-cycle read; sector 5 locked
    always @(posedge CLK) begin
        if (ARR.re) ARR_RDATA <= mem.exists(ARR.addr) ? mem[ARR.addr] : 16'hffff;
        if (ARR.we) mem[ARR.addr] = ARR.wdata;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    assign LOCK_HIT = LOCK_SECT == 7'h05;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= ad;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= ad;
        REG_WDATA <= v;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic cmd(input logic [23:0] ad, input logic [15:0] v);
        host.wd[0] = v;
        host.frame(ad, 1);
    endtask
    task automatic unl;
        cmd({13'h0, UNL1_ADDR}, {8'h0, UNL1_DATA});
        cmd({13'h0, UNL2_ADDR}, {8'h0, UNL2_DATA});
    endtask
    // Status once idle; aborts land a few cycles after the frame
    task automatic st(input logic [31:0] e);
        repeat (10) @(posedge CLK);
        d = 32'h0;
        for (int i = 0; i < 300 && d[STS_RDY] !== 1'b1; i++) rd(REG_STATUS);
        chk(d, e);
    endtask
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {RSTN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, ERS_SUSP} = '0;
        {CE, RESET_N} = 2'b11;
        {failures, compares, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd43};
        repeat (8) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(REG_CTRL);
        chk(d, 32'h0);
        rd(4'hc);
        chk(d, 32'h0);
        st(32'h80);
        for (int k = 0; k < 3; k++) begin
            a = {7'h0, 17'($random(seed))};
            p[0] = 16'($random(seed));
            p[1] = 16'($random(seed));
            mem[a] = p[0];
            if (k == 2) wr(REG_CTRL, 32'h2);
            else unl();
            cmd(a ^ 24'h3, {8'h0, CMD_SETUP});
            cmd(a, p[1]);
            // Last word is decoded a few cycles after chip select rises
            repeat (4) @(posedge CLK);
            rd(REG_STATUS);
            chk(32'(d[STS_RDY]), 32'h0);
            st(32'h80);
            chk(32'(mem[a]), 32'(p[0] & p[1]));
        end
        wr(REG_CTRL, 32'h0);
        $display("word program test done");
        for (int k = 0; k < 2; k++) begin
            n = 1 + $unsigned($random(seed)) % 8;
            sa = {7'h01, 9'($random(seed)), 8'h00};
            a = sa + 24'(256 - n);
            mem[a - 24'h1] = 16'h00ff;
            ERS_SUSP <= k[0];
            unl();
            cmd(sa, {8'h0, CMD_WBUF});
            cmd(sa + 24'h10, 16'(n - 1));
            for (int i = 0; i < n; i++) begin
                p[i] = 16'($random(seed));
                host.wd[i] = p[i];
                mem[a + 24'(i)] = 16'h5aff;
            end
            host.frame(a, n);
            cmd(sa, {8'h0, CMD_COMMIT});
            chk(32'(ERS_STBY), 32'(k));
            st(32'h80);
            for (int i = 0; i < n; i++) chk(32'(mem[a + 24'(i)]), 32'(16'h5aff & p[i]));
            chk(32'(mem[a - 24'h1]), 32'h00ff);
        end
        $display("buffer program test done");
        for (int k = 0; k < 4; k++) begin
            unl();
            cmd(sa, {8'h0, CMD_WBUF});
            cmd(k == 2 ? sa + 24'h40000 : sa, k == 0 ? MAX_WCNT + 16'h1 : 16'h1);
            host.wd[0] = 16'h0;
            host.wd[1] = 16'h0;
            if (k == 1) host.frame(sa + 24'hff, 2);
            if (k == 3) host.frame(sa, 2);
            if (k == 3) cmd(sa, 16'h0);
            st(32'h98);
            if (k[0]) unl();
            cmd(sa, {8'h0, k[0] ? CMD_ABRST : CMD_CLR});
            st(32'h80);
        end
        $display("abort test done");
        unl();
        cmd(24'h0, {8'h0, CMD_SETUP});
        cmd(24'h0a0000, 16'h0);
        st(32'h90);
        cmd(24'h0, {8'h0, CMD_CLR});
        for (int i = 0; i < 8; i++) host.wd[i] = 16'h0;
        unl();
        cmd(24'h0, {8'h0, CMD_SETUP});
        host.frame(24'h200, 8);
        cmd(24'h0, {8'h0, CMD_SUSP});
        repeat (4) @(posedge CLK);
        rd(REG_STATUS);
        chk(d, 32'h04);
        cmd(24'h0, {8'h0, CMD_RESUME});
        st(32'h80);
        chk(32'(mem[24'h207]), 32'h0);
        $display("suspend test done");
        unl();
        cmd(24'h0, {8'h0, CMD_SETUP});
        for (int i = 0; i < 8; i++) host.wd[i] = 16'h0;
        host.frame(24'h100, 8);
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b0;
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(REG_STATUS);
        chk(32'(d[STS_RDY]), 32'h0);
        st(32'h80);
        $display("reset pin test done");
        test_done();
    end
endmodule // tb
bind flash_prog_seq flash_prog_seq_props #(.PULSE_CYC(PULSE_CYC), .RPH_CYC(RPH_CYC)) props (
    .CLK(CLK), .RSTN(RSTN), .CE(CE), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ARR(ARR), .ARR_RDATA(ARR_RDATA),
    .ERS_STBY(ERS_STBY));
